// ==== logic/xcpc_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// R1 - oscillator_ok rises after start-up wait once amplitude detector sees enough swing
// R2 - oscillator_ok releases reset; clock output needs clock enable bit and good supplies
// R3 - load capacitor switches open in IDLE and Sleep to save current
// R4 - fraction word is sum of two parts taken from control registers 2 and 3
// R5 - radio frequency uses band integer plus half and fraction word plus 20.5
// R6 - single-channel software keeps fraction word within 3803 to 4053
// R7 - microcontroller clock is oscillator clock divided by three
// R8 - microcontroller clock nominal half duty; first period after enable may be short; the logic drives it high two of every three cycles
// R9 - core clock is oscillator clock divided by sixteen
// R10 - core clock times polling bit check and transmit baud rate
// R11 - bit timing period is core period times limit factor times 8,4,2,1
// R12 - power-on input high switches the transceiver on
// R13 - any of five push buttons low switches the transceiver on
// R14 - reset output low while supply output below reset threshold
// R15 - flags for digital rail good, supply good and battery low
// R16 - clearing supply enable turns supply off; only power-up turns it back on
// R17 - OFF mode with all rails disabled while aux input below threshold
// R18 - register accesses ignored in OFF mode
// R19 - leaving OFF by input or button enters IDLE, interrupts and sets status
// R20 - switch-on logic reset returns control registers to defaults
// R21 - low supply holds clock output low and disables register access
// R22 - dividers held while oscillator_ok low
module xcpc_top #(
    parameter int OSC_START_CYC = xcpc_pkg::OSC_START_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire xcpc_pkg::xcpc_reg_req_t reg_req_i,
    output logic [xcpc_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic power_on_i,
    input wire logic [xcpc_pkg::BTN_N-1:0] push_button_n_i,
    input wire logic amp_detect_i,
    input wire logic band_pin_i,
    input wire xcpc_pkg::xcpc_mon_t mon_i,
    output logic oscillator_ok_o,
    output logic reset_out_n_o,
    output logic mcu_clk_o,
    output logic core_clk_o,
    output logic core_tick_o,
    output logic bit_tick_o,
    output logic interrupt_o,
    output logic logic_reset_o,
    output logic [xcpc_pkg::FRAC_W-1:0] synth_fraction_word_o,
    output xcpc_pkg::xcpc_band_t rf_band_o,
    output logic load_cap_switch_one_o,
    output logic load_cap_switch_two_o,
    output logic analog_rail_en_o,
    output logic digital_rail_en_o,
    output logic supply_output_en_o
);
    xcpc_pkg::xcpc_mode_t mode_q;
    xcpc_pkg::xcpc_mode_t mode_d;
    logic [xcpc_pkg::DATA_W-1:0] ctrl1_q, ctrl2_q, ctrl3_q, ctrl4_q, ctrl6_q;
    logic [xcpc_pkg::DATA_W-1:0] ctrl3_wr;
    logic [xcpc_pkg::BTN_N:0] status_q;
    logic [xcpc_pkg::BTN_N:0] status_d;
    logic [xcpc_pkg::OSC_CNT_W-1:0] osc_cnt_q;
    logic drg_q, sog_q, batt_q, clk_on_q;
    logic wake_req, reg_ok, wr, rd, lr_d, leave_off;
    logic mcu_phase, core_phase, core_tick_w, core_tick_q, bit_tick_w;
    logic [xcpc_pkg::LIMIT_W-1:0] limit_eff;
    logic [1:0] br_shift;
    logic [xcpc_pkg::BIT_W-1:0] bit_period, bit_last;
    logic [xcpc_pkg::FRAC_W-1:0] frac_a, frac_b;

    ////////////////////////////////////////////////////////////////////////////////
    // power modes

    assign wake_req = power_on_i || !(&push_button_n_i); // see R12 see R13
    assign leave_off = (mode_q == xcpc_pkg::MODE_OFF) && (mode_d != xcpc_pkg::MODE_OFF);
    assign reg_ok = (mode_q != xcpc_pkg::MODE_OFF) && sog_q; // see R18 see R21
    assign wr = reg_req_i.we && reg_ok;
    assign rd = reg_req_i.re && reg_ok;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            xcpc_pkg::MODE_OFF: begin
                if (wake_req || mon_i.aux_above_thr) begin // see R17 see R19
                    mode_d = xcpc_pkg::MODE_IDLE;
                end
            end
            xcpc_pkg::MODE_IDLE, xcpc_pkg::MODE_SLEEP, xcpc_pkg::MODE_ACTIVE: begin
                if (wr && reg_req_i.addr == xcpc_pkg::ADR_CTRL1) begin
                    unique case (reg_req_i.wdata[xcpc_pkg::OPM_LSB +: xcpc_pkg::OPM_W])
                        xcpc_pkg::OPM_IDLE: mode_d = xcpc_pkg::MODE_IDLE;
                        xcpc_pkg::OPM_SLEEP: mode_d = xcpc_pkg::MODE_SLEEP;
                        xcpc_pkg::OPM_ACTIVE: mode_d = xcpc_pkg::MODE_ACTIVE;
                        xcpc_pkg::OPM_OFF: begin
                            if (!wake_req && !mon_i.aux_above_thr) begin
                                mode_d = xcpc_pkg::MODE_OFF;
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    // supply loss with the output enabled also restarts the control logic
    assign lr_d = leave_off // see R20
        || (sog_q && !mon_i.supply_above_reset_thr && ctrl3_q[xcpc_pkg::SOUTEN_BIT]);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= xcpc_pkg::MODE_OFF;
            logic_reset_o <= 1'b0;
        end else begin
            mode_q <= mode_d;
            logic_reset_o <= lr_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_rail_en_o <= 1'b0;
            digital_rail_en_o <= 1'b0;
            supply_output_en_o <= 1'b0;
            load_cap_switch_one_o <= 1'b0;
            load_cap_switch_two_o <= 1'b0;
        end else begin
            analog_rail_en_o <= (mode_q == xcpc_pkg::MODE_IDLE) // see R17
                || (mode_q == xcpc_pkg::MODE_ACTIVE);
            digital_rail_en_o <= (mode_q != xcpc_pkg::MODE_OFF);
            supply_output_en_o <= (mode_q != xcpc_pkg::MODE_OFF) // see R16
                && ctrl3_q[xcpc_pkg::SOUTEN_BIT];
            load_cap_switch_one_o <= (mode_q == xcpc_pkg::MODE_ACTIVE); // see R3
            load_cap_switch_two_o <= (mode_q == xcpc_pkg::MODE_ACTIVE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    // software may clear the supply enable but never set it again
    always_comb begin
        ctrl3_wr = reg_req_i.wdata;
        ctrl3_wr[xcpc_pkg::SOUTEN_BIT] = reg_req_i.wdata[xcpc_pkg::SOUTEN_BIT] // see R16
            && ctrl3_q[xcpc_pkg::SOUTEN_BIT];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl1_q <= xcpc_pkg::CTRL1_RST;
            ctrl2_q <= xcpc_pkg::CTRL2_RST;
            ctrl3_q <= xcpc_pkg::CTRL3_RST;
            ctrl4_q <= xcpc_pkg::CTRL4_RST;
            ctrl6_q <= xcpc_pkg::CTRL6_RST;
        end else if (logic_reset_o) begin // see R20
            ctrl1_q <= xcpc_pkg::CTRL1_RST;
            ctrl2_q <= xcpc_pkg::CTRL2_RST;
            ctrl3_q <= xcpc_pkg::CTRL3_RST;
            ctrl4_q <= xcpc_pkg::CTRL4_RST;
            ctrl6_q <= xcpc_pkg::CTRL6_RST;
        end else if (wr) begin // see R18
            unique case (reg_req_i.addr)
                xcpc_pkg::ADR_CTRL1: ctrl1_q <= reg_req_i.wdata;
                xcpc_pkg::ADR_CTRL2: ctrl2_q <= reg_req_i.wdata;
                xcpc_pkg::ADR_CTRL3: ctrl3_q <= ctrl3_wr;
                xcpc_pkg::ADR_CTRL4: ctrl4_q <= reg_req_i.wdata;
                xcpc_pkg::ADR_CTRL6: ctrl6_q <= reg_req_i.wdata;
                default: ;
            endcase
        end
    end

    // wake sources are latched as the block leaves OFF; a read clears, a set wins
    always_comb begin
        status_d = status_q;
        if (rd && reg_req_i.addr == xcpc_pkg::ADR_STATUS) begin
            status_d = '0;
        end
        if (leave_off) begin // see R19
            status_d[xcpc_pkg::ST_PWR] = status_d[xcpc_pkg::ST_PWR] || power_on_i;
            status_d[xcpc_pkg::ST_BTN_LSB +: xcpc_pkg::BTN_N] =
                status_d[xcpc_pkg::ST_BTN_LSB +: xcpc_pkg::BTN_N] | ~push_button_n_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= '0;
            interrupt_o <= 1'b0;
        end else begin
            status_q <= status_d;
            interrupt_o <= |status_d; // see R19
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (rd) begin
            unique case (reg_req_i.addr)
                xcpc_pkg::ADR_CTRL1: reg_rdata_o <= ctrl1_q;
                xcpc_pkg::ADR_CTRL2: reg_rdata_o <= ctrl2_q;
                xcpc_pkg::ADR_CTRL3: reg_rdata_o <= ctrl3_q;
                xcpc_pkg::ADR_CTRL4: reg_rdata_o <= ctrl4_q;
                xcpc_pkg::ADR_CTRL6: reg_rdata_o <= ctrl6_q;
                xcpc_pkg::ADR_STATUS: reg_rdata_o <= {2'b00, status_q};
                xcpc_pkg::ADR_MON: reg_rdata_o <= {3'h0, // see R6
                    (synth_fraction_word_o >= xcpc_pkg::FRAC_CLEAN_MIN)
                        && (synth_fraction_word_o <= xcpc_pkg::FRAC_CLEAN_MAX),
                    oscillator_ok_o, batt_q, sog_q, drg_q}; // see R15
                default: reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // supply monitors, oscillator start-up and reset output

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            drg_q <= 1'b0;
            sog_q <= 1'b0;
            batt_q <= 1'b0;
        end else begin
            drg_q <= mon_i.digital_rail_above; // see R15
            sog_q <= mon_i.supply_above_reset_thr;
            if (!mon_i.supply_above_batt_thr) begin
                batt_q <= 1'b1;
            end else if ((rd && reg_req_i.addr == xcpc_pkg::ADR_MON) || !reset_out_n_o) begin
                batt_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_cnt_q <= '0;
            oscillator_ok_o <= 1'b0;
        end else if (mode_q == xcpc_pkg::MODE_OFF) begin
            osc_cnt_q <= '0;
            oscillator_ok_o <= 1'b0;
        end else begin
            if (osc_cnt_q < xcpc_pkg::OSC_CNT_W'(OSC_START_CYC)) begin
                osc_cnt_q <= xcpc_pkg::OSC_CNT_W'(osc_cnt_q + 1'b1);
            end
            oscillator_ok_o <= (osc_cnt_q == xcpc_pkg::OSC_CNT_W'(OSC_START_CYC)) // see R1
                && amp_detect_i;
        end
    end

    // hysteresis: pulled low below the reset threshold, released above the battery one
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reset_out_n_o <= 1'b0;
        end else if (!sog_q || !oscillator_ok_o) begin // see R14
            reset_out_n_o <= 1'b0;
        end else if (mon_i.supply_above_batt_thr) begin // see R2
            reset_out_n_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock dividers

    xcpc_divider #(.CNT_W(xcpc_pkg::MCU_CNT_W)) u_mcu_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hold_i(!oscillator_ok_o), // see R22
        .step_i(1'b1),
        .last_i(xcpc_pkg::MCU_CNT_W'(xcpc_pkg::MCU_DIV - 1)), // see R7
        .tick_o(),
        .phase_o(mcu_phase)
    );

    xcpc_divider #(.CNT_W(xcpc_pkg::CORE_CNT_W)) u_core_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hold_i(!oscillator_ok_o),
        .step_i(1'b1),
        .last_i(xcpc_pkg::CORE_CNT_W'(xcpc_pkg::CORE_DIV - 1)), // see R9
        .tick_o(core_tick_w),
        .phase_o(core_phase)
    );

    // a zero limit factor is taken as one
    assign limit_eff = (ctrl4_q == '0) ? xcpc_pkg::LIMIT_W'(1) : ctrl4_q;
    assign br_shift = 2'(xcpc_pkg::BR_SHIFT_MAX) - ctrl6_q[xcpc_pkg::BR_W-1:0];
    assign bit_period = {3'h0, limit_eff} << br_shift; // see R11
    assign bit_last = xcpc_pkg::BIT_W'(bit_period - 1'b1);

    xcpc_divider #(.CNT_W(xcpc_pkg::BIT_W)) u_bit_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hold_i(!oscillator_ok_o),
        .step_i(core_tick_w), // see R10
        .last_i(bit_last),
        .tick_o(bit_tick_w),
        .phase_o()
    );

    // phase gating keeps the two-of-three-high shape; enabling mid-period may cut it short
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_on_q <= 1'b0;
            mcu_clk_o <= 1'b0;
            core_clk_o <= 1'b0;
            core_tick_q <= 1'b0;
            core_tick_o <= 1'b0;
            bit_tick_o <= 1'b0;
        end else begin
            clk_on_q <= ctrl3_q[xcpc_pkg::CLKON_BIT] && oscillator_ok_o // see R2
                && sog_q && drg_q; // see R21
            mcu_clk_o <= clk_on_q && mcu_phase; // see R8
            core_clk_o <= core_phase;
            // one more stage so the core tick lines up with the bit tick
            core_tick_q <= core_tick_w;
            core_tick_o <= core_tick_q;
            bit_tick_o <= bit_tick_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // synthesizer fraction word and band

    assign frac_a = {ctrl2_q, 5'h00};
    assign frac_b = {8'h00, ctrl3_q[xcpc_pkg::FRH_W-1:0]};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            synth_fraction_word_o <= '0;
            rf_band_o <= xcpc_pkg::BAND_24P5;
        end else begin
            synth_fraction_word_o <= xcpc_pkg::FRAC_W'(frac_a + frac_b); // see R4
            if (!band_pin_i) begin // see R5
                rf_band_o <= xcpc_pkg::BAND_64P5;
            end else if (ctrl1_q[xcpc_pkg::BAND_SEL_BIT]) begin
                rf_band_o <= xcpc_pkg::BAND_24P5;
            end else begin
                rf_band_o <= xcpc_pkg::BAND_32P5;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [xcpc_pkg::BIT_W-1:0] gap_q;
    logic gap_ok_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q <= '0;
            gap_ok_q <= 1'b0;
        end else if (!oscillator_ok_o || (wr && (reg_req_i.addr == xcpc_pkg::ADR_CTRL4
                || reg_req_i.addr == xcpc_pkg::ADR_CTRL6)) || logic_reset_o) begin
            gap_q <= '0;
            gap_ok_q <= 1'b0;
        end else if (core_tick_o) begin
            gap_q <= bit_tick_o ? '0 : xcpc_pkg::BIT_W'(gap_q + 1'b1);
            gap_ok_q <= gap_ok_q || bit_tick_o;
        end
    end

    a_osc_start_wait: assert property ($rose(oscillator_ok_o) |-> // see R1
        $past(osc_cnt_q) == xcpc_pkg::OSC_CNT_W'(OSC_START_CYC) && $past(amp_detect_i))
        else $error("oscillator_ok rose before start-up wait");
    a_reset_out_low: assert property (!sog_q |=> !reset_out_n_o) // see R14
        else $error("reset output high with low supply");
    a_clk_gate_cond: assert property ($rose(mcu_clk_o) |-> // see R2
        $past(ctrl3_q[xcpc_pkg::CLKON_BIT], 2) && $past(oscillator_ok_o, 2))
        else $error("mcu clock without enable and oscillator_ok");
    a_clk_low_supply: assert property (!sog_q |-> ##2 !mcu_clk_o) // see R21
        else $error("mcu clock toggles with low supply");
    a_mcu_clk_period: assert property ( // see R7
        $rose(mcu_clk_o) && $past(clk_on_q, 2) ##1 clk_on_q [*3] |-> $rose(mcu_clk_o))
        else $error("mcu clock period not three");
    a_core_tick_gap: assert property (core_tick_o |=> !core_tick_o [*8]) // see R9
        else $error("core tick too soon");
    a_bit_period: assert property (bit_tick_o && gap_ok_q && core_tick_o |-> // see R11
        xcpc_pkg::BIT_W'(gap_q + 1'b1) == bit_period)
        else $error("bit timing period wrong");
    a_off_no_access: assert property ( // see R18
        mode_q == xcpc_pkg::MODE_OFF && !logic_reset_o |=> $stable(ctrl3_q) && reg_rdata_o == '0)
        else $error("register changed in OFF mode");
    a_wake_status: assert property (leave_off && power_on_i |=> // see R19
        status_q[xcpc_pkg::ST_PWR] && interrupt_o && mode_q == xcpc_pkg::MODE_IDLE)
        else $error("wake by power-on input not flagged");
    a_switch_on_reset: assert property (leave_off |=> logic_reset_o ##1 // see R20
        ctrl3_q == xcpc_pkg::CTRL3_RST && ctrl1_q == xcpc_pkg::CTRL1_RST)
        else $error("control registers not defaulted on switch-on");
    a_caps_open: assert property ((mode_q == xcpc_pkg::MODE_IDLE // see R3
        || mode_q == xcpc_pkg::MODE_SLEEP) |=> !load_cap_switch_one_o && !load_cap_switch_two_o)
        else $error("load capacitors connected in idle or sleep");
    a_rails_off: assert property (mode_q == xcpc_pkg::MODE_OFF |=> // see R17
        !analog_rail_en_o && !digital_rail_en_o && !supply_output_en_o)
        else $error("rail enabled in OFF mode");
    a_sout_stays_off: assert property (!ctrl3_q[xcpc_pkg::SOUTEN_BIT] // see R16
        && !logic_reset_o |=> !ctrl3_q[xcpc_pkg::SOUTEN_BIT])
        else $error("supply enable set by software");
    a_fraction_sum: assert property ( // see R4
        wr && reg_req_i.addr == xcpc_pkg::ADR_CTRL2 ##1 !wr && !logic_reset_o |->
        ##1 synth_fraction_word_o[xcpc_pkg::FRAC_W-1:xcpc_pkg::FRAC_A_SHIFT]
            == $past(reg_req_i.wdata, 2))
        else $error("fraction word upper part wrong");

    c_button_wake: cover property (leave_off && !(&push_button_n_i));
    c_mcu_clk_run: cover property ($rose(mcu_clk_o) ##3 $rose(mcu_clk_o));
    c_off_command: cover property (mode_q != xcpc_pkg::MODE_OFF ##1 mode_q == xcpc_pkg::MODE_OFF);
    c_bit_tick: cover property (bit_tick_o && gap_ok_q);
endmodule

// ==== common/xcpc_pkg.sv ====
package xcpc_pkg;
    // register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADR_CTRL1 = 3'h0;
    localparam logic [ADDR_W-1:0] ADR_CTRL2 = 3'h1;
    localparam logic [ADDR_W-1:0] ADR_CTRL3 = 3'h2;
    localparam logic [ADDR_W-1:0] ADR_CTRL4 = 3'h3;
    localparam logic [ADDR_W-1:0] ADR_MON = 3'h4;
    localparam logic [ADDR_W-1:0] ADR_CTRL6 = 3'h5;
    localparam logic [ADDR_W-1:0] ADR_STATUS = 3'h6;

    // control register 1: operating mode request and band select
    localparam int OPM_LSB = 0;
    localparam int OPM_W = 2;
    localparam int BAND_SEL_BIT = 4;
    localparam logic [OPM_W-1:0] OPM_IDLE = 2'h0;
    localparam logic [OPM_W-1:0] OPM_SLEEP = 2'h1;
    localparam logic [OPM_W-1:0] OPM_ACTIVE = 2'h2;
    localparam logic [OPM_W-1:0] OPM_OFF = 2'h3;
    // control register 3: lower fraction bits, clock and supply enables
    localparam int FRH_W = 5;
    localparam int CLKON_BIT = 5;
    localparam int SOUTEN_BIT = 6;
    // control register 6: baud range in the low bits
    localparam int BR_W = 2;
    // monitor register bits
    localparam int MON_DRG = 0;
    localparam int MON_SOG = 1;
    localparam int MON_BATT = 2;
    localparam int MON_OSC = 3;
    localparam int MON_CLEAN = 4;
    // status register: bit 0 power-on input, bits 1..5 push buttons
    localparam int ST_PWR = 0;
    localparam int ST_BTN_LSB = 1;
    localparam int BTN_N = 5;

    localparam logic [DATA_W-1:0] CTRL1_RST = 8'h00;
    localparam logic [DATA_W-1:0] CTRL2_RST = 8'h00;
    localparam logic [DATA_W-1:0] CTRL3_RST = 8'h60;
    localparam logic [DATA_W-1:0] CTRL4_RST = 8'h01;
    localparam logic [DATA_W-1:0] CTRL6_RST = 8'h00;

    // synthesizer fraction word
    localparam int FRAC_W = 13;
    localparam int FRAC_A_SHIFT = 5;
    localparam logic [FRAC_W-1:0] FRAC_CLEAN_MIN = 13'h0edb;
    localparam logic [FRAC_W-1:0] FRAC_CLEAN_MAX = 13'h0fd5;

    // clock dividers
    localparam int MCU_DIV = 3;
    localparam int CORE_DIV = 16;
    localparam int MCU_CNT_W = 2;
    localparam int CORE_CNT_W = 4;
    localparam int LIMIT_W = 8;
    localparam int BR_SHIFT_MAX = 3;
    localparam int BIT_W = LIMIT_W + BR_SHIFT_MAX;

    // oscillator start-up: least wait is ten time constants
    localparam int CLK_PERIOD_NS = 25;
    localparam int XTO_TAU_NS = 100;
    localparam int START_TAU_MIN = 10;
    localparam int OSC_START_CYC =
        (START_TAU_MIN * XTO_TAU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_CNT_W = 12;

    typedef enum logic [1:0] {MODE_OFF, MODE_IDLE, MODE_SLEEP, MODE_ACTIVE} xcpc_mode_t;
    typedef enum logic [1:0] {BAND_24P5, BAND_32P5, BAND_64P5} xcpc_band_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } xcpc_reg_req_t;

    // comparator outputs of the analog voltage monitors
    typedef struct packed {
        logic digital_rail_above;
        logic supply_above_reset_thr;
        logic supply_above_batt_thr;
        logic aux_above_thr;
    } xcpc_mon_t;
endpackage

// ==== logic/xcpc_divider.sv ====
`timescale 1ns/10ps
module xcpc_divider #(
    parameter int CNT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic step_i,
    input wire logic [CNT_W-1:0] last_i,
    output logic tick_o,
    output logic phase_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W:0] half;

    always_comb begin
        half = ({1'b0, last_i} + (CNT_W+1)'(2)) >> 1;
        cnt_d = cnt_q;
        if (step_i) begin
            cnt_d = (cnt_q >= last_i) ? '0 : CNT_W'(cnt_q + 1'b1);
        end
    end

    // hold restarts the count so the derived clock starts at a known phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            tick_o <= 1'b0;
            phase_o <= 1'b0;
        end else if (hold_i) begin
            cnt_q <= '0;
            tick_o <= 1'b0;
            phase_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_o <= step_i && (cnt_q >= last_i);
            phase_o <= ({1'b0, cnt_d} < half);
        end
    end
endmodule

// ==== bench/xcpc_mcu_model.sv ====
`timescale 1ns/10ps
module xcpc_mcu_model (
    input wire logic mcu_clk_i,
    input wire logic rst_n_i,
    output int edges_o
);
    // counts clock edges seen out of reset
    always_ff @(posedge mcu_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edges_o <= 0;
        end else begin
            edges_o <= edges_o + 1;
        end
    end
endmodule

// ==== bench/xcpc_top_tb.sv ====
`timescale 1ns/10ps
module xcpc_top_tb;
    logic clk_i = 0;
    logic rst_i = 1;
    logic pwr = 0;
    xcpc_pkg::xcpc_reg_req_t req = '0;
    xcpc_pkg::xcpc_mon_t mon = 4'b1110;
    logic [7:0] rdata;
    logic osc, rst_n, mclk, ctk, btk, irq, lc1, lc2, arail, drail, sen, lrst;
    logic [1:0] band;
    logic [4:0] btn = 5'h1f;
    logic [12:0] frac;
    int edges, error_cnt = 0, compares = 0, cyc = 0;
    always #12.5 clk_i = ~clk_i;
    xcpc_top #(.OSC_START_CYC(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .power_on_i(pwr), .push_button_n_i(btn), .amp_detect_i(1'b1),
        .band_pin_i(1'b1), .mon_i(mon), .oscillator_ok_o(osc), .reset_out_n_o(rst_n),
        .mcu_clk_o(mclk), .core_clk_o(), .core_tick_o(ctk), .bit_tick_o(btk),
        .interrupt_o(irq), .logic_reset_o(lrst), .synth_fraction_word_o(frac), .rf_band_o(band),
        .load_cap_switch_one_o(lc1), .load_cap_switch_two_o(lc2), .analog_rail_en_o(arail),
        .digital_rail_en_o(drail), .supply_output_en_o(sen));
    xcpc_mcu_model mcu (.mcu_clk_i(mclk), .rst_n_i(rst_n), .edges_o(edges));
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_of_test;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.we <= 1'b1;
        @(posedge clk_i) req.we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        req.addr <= a;
        req.re <= 1'b1;
        @(posedge clk_i) req.re <= 1'b0;
        #1 check(rdata, e);
        @(posedge clk_i);
    endtask
    // counts core or bit ticks over n cycles
    task automatic cnt(input int n, input bit bt, input int e);
        int c = 0;
        repeat (n) begin
            @(posedge clk_i);
            #1 c += int'(bt ? btk : ctk);
        end
        check(c, e);
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test;
        end
    end
    initial begin
        int e0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(xcpc_pkg::ADR_CTRL1, 8'h02);
        rd(xcpc_pkg::ADR_CTRL1, 8'h00);
        check(arail, 0);
        pwr <= 1'b1;
        @(posedge clk_i) pwr <= 1'b0;
        #1 check(irq, 1);
        repeat (20) @(posedge clk_i);
        check({osc, rst_n, arail, lc1, lc2, sen, drail}, 7'b1110011);
        check(band, xcpc_pkg::BAND_32P5);
        rd(xcpc_pkg::ADR_STATUS, 8'h01);
        rd(xcpc_pkg::ADR_CTRL3, 8'h60);
        wr(xcpc_pkg::ADR_CTRL2, 8'h77);
        wr(xcpc_pkg::ADR_CTRL3, 8'h67);
        #1 check(frac, 13'h0ee7);
        rd(xcpc_pkg::ADR_MON, 8'h1b);
        e0 = edges;
        repeat (48) @(posedge clk_i);
        check(edges - e0, 16);
        cnt(64, 0, 4);
        wr(xcpc_pkg::ADR_CTRL4, 8'h02);
        wr(xcpc_pkg::ADR_CTRL6, 8'h03);
        cnt(128, 1, 4);
        mon <= 4'b1000;
        @(posedge clk_i);
        #1 check(lrst, 1);
        repeat (3) @(posedge clk_i);
        #1 check({rst_n, mclk}, 0);
        mon <= 4'b1110;
        @(posedge clk_i);
        wr(xcpc_pkg::ADR_CTRL1, 8'h03);
        #1 check(drail, 0);
        btn <= 5'h1d;
        @(posedge clk_i) btn <= 5'h1f;
        #1 check(irq, 1);
        rd(xcpc_pkg::ADR_STATUS, 8'h04);
        end_of_test;
    end
endmodule
